/* File: verilog/fmbc_cfg.svh */
// constants for flash mode and boot control
// Function
// - user mode reads flash, never programs
// - program/erase only boot, user program, prom
// - no boot or user program in mode 6
// - write enable pin level selects programming
// - overlay block reads come from ram
// - eight blocks: 3x32k, 28k, 4x1k
// - erase whole blocks only
// - boot entry erases whole array to ff
// - programming pins at reset permit programming
// - pins pick boot or user program
// - boot shows mode pins, pin 2 inverted
// - boot loads over serial channel 1
// - received bytes stored sequentially in ram
// - branch to fff520 only on id match
// - boot copies erase routine into ram
// - overlay select protects all blocks
`ifndef FMBC_CFG_SVH
`define FMBC_CFG_SVH
`define FMBC_MODE_CONTROL_REGISTER_OFF 8'h00
`define FMBC_RAM_OVERLAY_CONTROL_OFF 8'h04
`define FMBC_FLASH_CONTROL_REG_1_OFF 8'h08
`define FMBC_STAT_OFF 8'h0C
`define FMBC_RAM_OVERLAY_CONTROL_RST 8'hF1
`define FMBC_RAM_OVERLAY_SELECT_BIT 3
`define FMBC_FLASH_CONTROL_REG_1_RST 8'h00
`define FMBC_BRANCH_ADDR 24'hFFF520
`define FMBC_OVL_BASE 24'hFFF000
`define FMBC_BOOT_BASE 24'hFFF000
`define FMBC_ERASED 8'hFF
`define FMBC_MODE6 3'h6
`define FMBC_ID_LEN 16'h0008
`define FMBC_LAST_BLK 3'h7
`define FMBC_CAP_WAIT 2'h3
`define FMBC_SER_CHAN 2'h1
`endif

/* File: verilog/fmbc_pkg.sv */
// types for flash mode and boot control
package fmbc_pkg;
    typedef enum logic [1:0] {
        FMBC_USER, FMBC_BOOT, FMBC_UPROG, FMBC_PROM
    } fmbc_fmode_t;
    typedef enum logic [2:0] {
        FMBC_IDLE, FMBC_COPY, FMBC_ERASE, FMBC_LOAD, FMBC_RUN, FMBC_FAIL
    } fmbc_bst_t;
endpackage

/* File: verilog/fmbc_boot_seq.sv */
// boot sequencer: copy routine, erase all, load program, check id
`timescale 1ns/10ps
`include "fmbc_cfg.svh"
module fmbc_boot_seq import fmbc_pkg::*; #(
    parameter int COPY_LEN = 64,
    parameter int PROG_LEN = 256,
    parameter logic [63:0] ID_CODE = 64'h0123456789ABCDEF // arbitrary
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic [15:0] rom_addr,
    input wire logic [7:0] rom_data,
    output logic erase_req,
    output logic [2:0] erase_blk,
    input wire logic erase_done,
    output logic ram_we,
    output logic [23:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic branch,
    output logic [23:0] branch_addr,
    output logic id_fail,
    output fmbc_bst_t state
);
    fmbc_bst_t st_reg, st_next;
    logic [15:0] idx_reg, idx_next;
    logic [2:0] blk_reg, blk_next;
    logic cp_reg, cp_next;
    logic [15:0] cpa_reg, cpa_next;
    logic ok_reg, ok_next;
    logic we_reg, we_next;
    logic [23:0] wa_reg, wa_next;
    logic [7:0] wd_reg, wd_next;
    logic br_reg, br_next;

    always_comb begin
        st_next = st_reg;
        idx_next = idx_reg;
        blk_next = blk_reg;
        cp_next = 1'b0;
        cpa_next = idx_reg;
        ok_next = ok_reg;
        we_next = 1'b0;
        wa_next = wa_reg;
        wd_next = wd_reg;
        br_next = 1'b0;
        if (cp_reg) begin
            we_next = 1'b1;
            wa_next = `FMBC_BOOT_BASE + {8'h00, cpa_reg};
            wd_next = rom_data;
        end
        case (st_reg)
            FMBC_IDLE: begin
                if (start) begin
                    st_next = FMBC_COPY;
                    idx_next = 16'h0000;
                end
            end
            FMBC_COPY: begin
                cp_next = 1'b1;
                idx_next = idx_reg + 16'h0001;
                if (idx_reg == 16'(COPY_LEN - 1)) begin
                    st_next = FMBC_ERASE;
                    blk_next = 3'h0;
                end
            end
            FMBC_ERASE: begin
                // every block, whether or not it holds data
                if (erase_done) begin
                    blk_next = blk_reg + 3'h1;
                    if (blk_reg == `FMBC_LAST_BLK) begin
                        st_next = FMBC_LOAD;
                        idx_next = 16'h0000;
                        ok_next = 1'b1;
                    end
                end
            end
            FMBC_LOAD: begin
                if (rx_valid) begin
                    we_next = 1'b1;
                    wa_next = `FMBC_BRANCH_ADDR + {8'h00, idx_reg};
                    wd_next = rx_data;
                    idx_next = idx_reg + 16'h0001;
                    if (idx_reg < `FMBC_ID_LEN &&
                        rx_data != ID_CODE[8'(63 - 8 * idx_reg[2:0]) -: 8])
                    begin
                        ok_next = 1'b0;
                    end
                    if (idx_reg == 16'(PROG_LEN - 1)) begin
                        st_next = (ok_next) ? FMBC_RUN : FMBC_FAIL;
                        br_next = ok_next;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= FMBC_IDLE;
            idx_reg <= 16'h0000;
            blk_reg <= 3'h0;
            cp_reg <= 1'b0;
            cpa_reg <= 16'h0000;
            ok_reg <= 1'b0;
            we_reg <= 1'b0;
            wa_reg <= 24'h000000;
            wd_reg <= 8'h00;
            br_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            idx_reg <= idx_next;
            blk_reg <= blk_next;
            cp_reg <= cp_next;
            cpa_reg <= cpa_next;
            ok_reg <= ok_next;
            we_reg <= we_next;
            wa_reg <= wa_next;
            wd_reg <= wd_next;
            br_reg <= br_next;
        end
    end

    assign rom_addr = idx_reg;
    assign erase_req = (st_reg == FMBC_ERASE);
    assign erase_blk = blk_reg;
    assign ram_we = we_reg;
    assign ram_addr = wa_reg;
    assign ram_wdata = wd_reg;
    assign branch = br_reg;
    assign branch_addr = `FMBC_BRANCH_ADDR;
    assign id_fail = (st_reg == FMBC_FAIL);
    assign state = st_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_branch_needs_id: assert property (
        br_reg |-> ok_reg && st_reg == FMBC_RUN)
        else $error("branch without id match");
    sequence s_erase_last;
        st_reg == FMBC_ERASE && blk_reg == `FMBC_LAST_BLK && erase_done;
    endsequence
    a_erase_then_load: assert property (
        s_erase_last |=> st_reg == FMBC_LOAD && blk_reg == 3'h0)
        else $error("load began before all blocks erased");
    a_load_store: assert property (
        st_reg == FMBC_LOAD && rx_valid |=> we_reg && wd_reg == $past(rx_data))
        else $error("received byte not stored");
endmodule

/* File: verilog/fmbc_top.sv */
// flash mode selection, programming permission and overlay control
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "fmbc_cfg.svh"
module fmbc_top import fmbc_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int COPY_LEN = 64,
    parameter int PROG_LEN = 256
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic flash_write_enable_pin,
    input wire logic mode_pin_0,
    input wire logic mode_pin_1,
    input wire logic mode_pin_2,
    input wire logic prom_mode_pin,
    input wire logic flash_rd,
    input wire logic [16:0] flash_addr,
    output logic rd_from_ram,
    output logic [23:0] rd_ram_addr,
    output logic [2:0] rd_block,
    input wire logic pe_req,
    input wire logic pe_erase,
    input wire logic [7:0] pe_erase_sel,
    output logic pe_grant,
    output logic [15:0] rom_addr,
    input wire logic [7:0] rom_data,
    output logic boot_erase_req,
    output logic [2:0] boot_erase_blk,
    input wire logic erase_done,
    input wire logic ser_rx_valid,
    input wire logic [7:0] ser_rx_data,
    output logic ram_we,
    output logic [23:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic cpu_branch,
    output logic [23:0] cpu_branch_addr
);
    ////////////////////////////////////////////////////////////////////
    // block layout
    function automatic logic [2:0] blk_of(input logic [16:0] a);
        if (a < 17'h01000) begin
            blk_of = {1'b0, a[11:10]};
        end else if (a < 17'h08000) begin
            blk_of = 3'h4;
        end else begin
            blk_of = 3'h4 + {1'b0, a[16:15]};
        end
    endfunction

    function automatic logic onehot8(input logic [7:0] v);
        onehot8 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and mode capture
    logic [4:0] pin_s1_reg, pin_s2_reg;
    logic [1:0] cap_cnt_reg, cap_cnt_next;
    logic cap_done_reg, cap_done_next;
    logic [4:0] pins_reg, pins_next;

    always_comb begin
        cap_cnt_next = cap_cnt_reg;
        cap_done_next = cap_done_reg;
        pins_next = pins_reg;
        if (!cap_done_reg) begin
            cap_cnt_next = cap_cnt_reg + 2'h1;
            if (cap_cnt_reg == `FMBC_CAP_WAIT) begin
                cap_done_next = 1'b1;
                pins_next = pin_s2_reg;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_reg <= 5'h00;
            pin_s2_reg <= 5'h00;
            cap_cnt_reg <= 2'h0;
            cap_done_reg <= 1'b0;
            pins_reg <= 5'h00;
        end else begin
            pin_s1_reg <= {prom_mode_pin, flash_write_enable_pin,
                mode_pin_2, mode_pin_1, mode_pin_0};
            pin_s2_reg <= pin_s1_reg;
            cap_cnt_reg <= cap_cnt_next;
            cap_done_reg <= cap_done_next;
            pins_reg <= pins_next;
        end
    end

    // pins change only across a reset, so the latched copy is the mode
    logic fwe_l, prom_l, obp;
    logic [2:0] pin_md, mode_num;
    fmbc_fmode_t fmode;
    assign prom_l = pins_reg[4];
    assign fwe_l = pins_reg[3];
    assign pin_md = pins_reg[2:0];
    // boot straps mode pin 2 low, yet the chip runs in mode 5 or 7
    assign obp = cap_done_reg && fwe_l && pin_md[0];
    assign mode_num = obp ? {1'b1, pin_md[1], 1'b1} : pin_md;

    always_comb begin
        if (!cap_done_reg) begin
            fmode = FMBC_USER;
        end else if (prom_l) begin
            fmode = FMBC_PROM;
        end else if (obp && mode_num != `FMBC_MODE6) begin
            fmode = pin_md[2] ? FMBC_UPROG : FMBC_BOOT;
        end else begin
            fmode = FMBC_USER;
        end
    end

    logic pe_perm;
    assign pe_perm = (fmode != FMBC_USER);

    ////////////////////////////////////////////////////////////////////
    // registers and axi4-lite slave
    logic [7:0] ram_overlay_control_reg, ram_overlay_control_next;
    logic [7:0] flash_control_reg_1_reg, flash_control_reg_1_next;
    logic aw_have_reg, aw_have_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic w_have_reg, w_have_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_lane_reg, w_lane_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic ram_overlay_select;
    logic [7:0] mode_control_register_val, stat_val;
    fmbc_bst_t bst;
    logic id_fail;

    assign ram_overlay_select = ram_overlay_control_reg[`FMBC_RAM_OVERLAY_SELECT_BIT];
    // in boot mode mode pin 2 is shown inverted
    assign mode_control_register_val = (fmode == FMBC_BOOT) ?
        {5'h00, ~pin_md[2], pin_md[1:0]} : {5'h00, mode_num};
    assign stat_val = {`FMBC_SER_CHAN, id_fail, bst, fmode};

    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready = !w_have_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;

    always_comb begin
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_lane_next = w_lane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        ram_overlay_control_next = ram_overlay_control_reg;
        flash_control_reg_1_next = flash_control_reg_1_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata[7:0];
            w_lane_next = s_axi_wstrb[0];
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (aw_have_reg && w_have_reg) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = 2'b00;
            if (aw_addr_reg == `FMBC_RAM_OVERLAY_CONTROL_OFF) begin
                // mode 6 keeps overlay select clear; modes below 5 ignore the write
                if (w_lane_reg && mode_num >= 3'h5) begin
                    ram_overlay_control_next = {4'hF, w_data_reg[3] &&
                        (mode_num != `FMBC_MODE6), w_data_reg[2:1], 1'b1};
                end
            end else if (aw_addr_reg == `FMBC_FLASH_CONTROL_REG_1_OFF) begin
                if (w_lane_reg && pe_perm) begin
                    flash_control_reg_1_next = w_data_reg;
                end
            end else if (aw_addr_reg == `FMBC_MODE_CONTROL_REGISTER_OFF ||
                aw_addr_reg == `FMBC_STAT_OFF) begin
                bresp_next = 2'b00;
            end else begin
                bresp_next = 2'b10;
            end
        end
        // control reg 1 is meaningless without programming permission
        if (!pe_perm) begin
            flash_control_reg_1_next = `FMBC_FLASH_CONTROL_REG_1_RST;
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = 2'b00;
            if (s_axi_araddr == `FMBC_MODE_CONTROL_REGISTER_OFF) begin
                rdata_next = {24'h000000, mode_control_register_val};
            end else if (s_axi_araddr == `FMBC_RAM_OVERLAY_CONTROL_OFF) begin
                rdata_next = {24'h000000, ram_overlay_control_reg};
            end else if (s_axi_araddr == `FMBC_FLASH_CONTROL_REG_1_OFF) begin
                rdata_next = {24'h000000, flash_control_reg_1_reg};
            end else if (s_axi_araddr == `FMBC_STAT_OFF) begin
                rdata_next = {24'h000000, stat_val};
            end else begin
                rdata_next = 32'h00000000;
                rresp_next = 2'b10;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_have_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= 2'b00;
            ram_overlay_control_reg <= `FMBC_RAM_OVERLAY_CONTROL_RST;
            flash_control_reg_1_reg <= `FMBC_FLASH_CONTROL_REG_1_RST;
        end else begin
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_lane_reg <= w_lane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            ram_overlay_control_reg <= ram_overlay_control_next;
            flash_control_reg_1_reg <= flash_control_reg_1_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    ////////////////////////////////////////////////////////////////////
    // flash read steering and program/erase gating
    logic rfr_reg, rfr_next;
    logic [23:0] rra_reg, rra_next;
    logic [2:0] rblk_reg, rblk_next;
    logic grant_reg, grant_next;

    always_comb begin
        rfr_next = 1'b0;
        rra_next = rra_reg;
        rblk_next = rblk_reg;
        grant_next = 1'b0;
        if (flash_rd) begin
            rblk_next = blk_of(flash_addr);
            // overlay window only covers the four small blocks
            rfr_next = ram_overlay_select &&
                blk_of(flash_addr) == {1'b0, ram_overlay_control_reg[2:1]};
            rra_next = `FMBC_OVL_BASE + {14'h0000, flash_addr[9:0]};
        end
        // erase names one block; several or none is refused
        if (pe_req && pe_perm && !ram_overlay_select && flash_control_reg_1_reg != 8'h00 &&
            (!pe_erase || onehot8(pe_erase_sel))) begin
            grant_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rfr_reg <= 1'b0;
            rra_reg <= 24'h000000;
            rblk_reg <= 3'h0;
            grant_reg <= 1'b0;
        end else begin
            rfr_reg <= rfr_next;
            rra_reg <= rra_next;
            rblk_reg <= rblk_next;
            grant_reg <= grant_next;
        end
    end

    assign rd_from_ram = rfr_reg;
    assign rd_ram_addr = rra_reg;
    assign rd_block = rblk_reg;
    assign pe_grant = grant_reg;

    ////////////////////////////////////////////////////////////////////
    // boot sequencer; load area starts above the overlay window
    logic seq_erase;
    fmbc_boot_seq #(
        .COPY_LEN(COPY_LEN),
        .PROG_LEN(PROG_LEN)
    ) u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(fmode == FMBC_BOOT),
        .rx_valid(ser_rx_valid),
        .rx_data(ser_rx_data),
        .rom_addr(rom_addr),
        .rom_data(rom_data),
        .erase_req(seq_erase),
        .erase_blk(boot_erase_blk),
        .erase_done(erase_done),
        .ram_we(ram_we),
        .ram_addr(ram_addr),
        .ram_wdata(ram_wdata),
        .branch(cpu_branch),
        .branch_addr(cpu_branch_addr),
        .id_fail(id_fail),
        .state(bst)
    );
    assign boot_erase_req = seq_erase && (fmode == FMBC_BOOT);

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_user_no_pe: assert property (
        fmode == FMBC_USER |=> !grant_reg)
        else $error("program or erase granted in user mode");
    a_mode6_no_obp: assert property (
        mode_num == `FMBC_MODE6 |-> fmode inside {FMBC_USER, FMBC_PROM})
        else $error("boot or user program in mode 6");
    a_overlay_read: assert property (
        flash_rd && ram_overlay_select && flash_addr < 17'h01000 &&
        flash_addr[11:10] == ram_overlay_control_reg[2:1] |=> rfr_reg)
        else $error("overlay block read not steered to ram");
    a_ram_overlay_select_protect: assert property (
        ram_overlay_select |=> !grant_reg)
        else $error("grant while overlay selected");
    a_erase_onehot: assert property (
        pe_req && pe_erase && !onehot8(pe_erase_sel) |=> !grant_reg)
        else $error("multi-block erase granted");
    a_mode_hold: assert property (
        cap_done_reg |=> $stable(pins_reg) && cap_done_reg)
        else $error("latched mode changed after capture");
    a_mode_control_register_invert: assert property (
        fmode == FMBC_BOOT |-> mode_control_register_val[2] == !pin_md[2])
        else $error("boot mode pin 2 not inverted");
endmodule

/* File: tb/fmbc_host_model.sv */
// host side model: boot rom, flash erase engine and serial sender
`timescale 1ns/10ps
module fmbc_host_model (
    input wire logic aclk,
    input wire logic [15:0] rom_addr,
    output logic [7:0] rom_data,
    input wire logic boot_erase_req,
    output logic erase_done,
    output logic ser_rx_valid,
    output logic [7:0] ser_rx_data
);
logic [1:0] cnt_reg;
initial begin
    rom_data = 8'h00;
    erase_done = 1'h0;
    cnt_reg = 2'h0;
    ser_rx_valid = 1'h0;
    ser_rx_data = 8'hFF;
end
////////////////////////////////////////
// rom is synchronous; erase takes four cycles per block, slow on purpose
always @(posedge aclk) begin
    rom_data <= ~rom_addr[7:0];
    if (boot_erase_req && !erase_done) begin
        cnt_reg <= cnt_reg + 2'h1;
        erase_done <= (cnt_reg == 2'h3);
    end else begin
        cnt_reg <= 2'h0;
        erase_done <= 1'h0;
    end
end
// idle data is the inverse of the last byte, never a stale copy
task automatic send(input logic [7:0] b, input int gap);
    @(posedge aclk);
    ser_rx_valid <= 1'h1;
    ser_rx_data <= b;
    @(posedge aclk);
    ser_rx_valid <= 1'h0;
    ser_rx_data <= ~b;
    repeat (gap) @(posedge aclk);
endtask
endmodule

/* File: tb/flash_mode_and_boot_control_test.sv */
// self-checking bench for flash mode and boot control
`timescale 1ns/10ps
module flash_mode_and_boot_control_test;
logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
logic s_axi_arready, s_axi_rvalid, s_axi_rready, flash_write_enable_pin;
logic mode_pin_0, mode_pin_1, mode_pin_2, prom_mode_pin, flash_rd;
logic rd_from_ram, pe_req, pe_erase, pe_grant, boot_erase_req;
logic erase_done, ser_rx_valid, ram_we, cpu_branch;
logic [7:0] s_axi_awaddr, s_axi_araddr, pe_erase_sel, rom_data, d;
logic [7:0] ser_rx_data, ram_wdata;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [16:0] flash_addr;
logic [23:0] rd_ram_addr, ram_addr, cpu_branch_addr;
logic [2:0] rd_block, boot_erase_blk;
logic [15:0] rom_addr;
logic [31:0] wq[$];
logic [2:0] eq[$];
int errors, total_checks, nbr;
localparam logic [63:0] ID = 64'h0123456789ABCDEF;
fmbc_top #(.COPY_LEN(4), .PROG_LEN(16)) dut (.*);
fmbc_host_model host (.*);
initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
end
always @(posedge aclk) begin
    if (ram_we === 1'h1) wq.push_back({ram_addr, ram_wdata});
    if (boot_erase_req === 1'h1 && erase_done === 1'h1)
        eq.push_back(boot_erase_blk);
    if (cpu_branch === 1'h1) nbr++;
end
////////////////////////////////////////
task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
        errors++;
        $display("ERROR %s expected %h seen %h", n, e, g);
    end
endtask
task automatic test_done;
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
task automatic wr(input logic [7:0] a, v, input logic [1:0] r);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
        @(posedge aclk);
        if (!aw && s_axi_awready) begin
            aw = 1'h1;
            s_axi_awvalid <= 1'h0;
        end
        if (!w && s_axi_wready) begin
            w = 1'h1;
            s_axi_wvalid <= 1'h0;
        end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", r, s_axi_bresp);
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] v,
        input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    v = s_axi_rdata[7:0];
    chk("rresp", r, s_axi_rresp);
endtask
task automatic rchk(input logic [7:0] a, e);
    rd(a, d, 2'h0);
    chk($sformatf("reg %h", a), e, d);
endtask
task automatic rst(input logic f, m2, m1, m0);
    wq.delete();
    eq.delete();
    nbr = 0;
    @(posedge aclk);
    aresetn <= 1'h0;
    flash_write_enable_pin <= f;
    mode_pin_2 <= m2;
    mode_pin_1 <= m1;
    mode_pin_0 <= m0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (6) @(posedge aclk);
endtask
task automatic pe(input logic er, input logic [7:0] s, input logic g);
    @(posedge aclk);
    pe_req <= 1'h1;
    pe_erase <= er;
    pe_erase_sel <= s;
    @(posedge aclk);
    pe_req <= 1'h0;
    @(posedge aclk);
    chk("pe_grant", g, pe_grant);
endtask
task automatic fr(input logic [16:0] a, input logic r, input logic [2:0] b);
    @(posedge aclk);
    flash_rd <= 1'h1;
    flash_addr <= a;
    @(posedge aclk);
    flash_rd <= 1'h0;
    @(posedge aclk);
    chk("rd_from_ram", r, rd_from_ram);
    chk("rd_block", b, rd_block);
    if (r) chk("rd_ram_addr", 24'hFFF000 + a[9:0], rd_ram_addr);
endtask
function automatic logic [7:0] eb(input int n);
    return n < 8 ? ID[63-8*n -: 8] : 8'h10 + n[7:0];
endfunction
// loading only starts once the erase pass is over, or bytes are dropped
task automatic boot(input logic bad);
    rst(1'h1, 1'h0, 1'h0, 1'h1);
    rchk(8'h00, 8'h05);
    do rd(8'h0C, d, 2'h0); while (d[4:2] !== 3'h3);
    for (int n = 0; n < 16; n++)
        host.send(eb(n) ^ {7'h0, bad && n == 0}, n % 3);
    repeat (4) @(posedge aclk);
endtask
////////////////////////////////////////
initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, flash_rd, pe_req, pe_erase} = 5'h0;
    {flash_write_enable_pin, mode_pin_2, mode_pin_1, mode_pin_0} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, pe_erase_sel, flash_addr} = 41'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    prom_mode_pin = 1'h0;
    rst(1'h0, 1'h1, 1'h1, 1'h1);
    rchk(8'h0C, 8'h40);
    rchk(8'h00, 8'h07);
    wr(8'h08, 8'h01, 2'h0);
    rchk(8'h08, 8'h00);
    pe(1'h0, 8'h00, 1'h0);
    wr(8'h10, 8'h01, 2'h2);
    rd(8'h10, d, 2'h2);
    chk("unmapped", 8'h00, d);
    prom_mode_pin <= 1'h1;
    rst(1'h0, 1'h0, 1'h1, 1'h1);
    rchk(8'h0C, 8'h43);
    wr(8'h08, 8'h01, 2'h0);
    pe(1'h0, 8'h00, 1'h1);
    prom_mode_pin <= 1'h0;
    rst(1'h1, 1'h1, 1'h1, 1'h0);
    wr(8'h04, 8'h08, 2'h0);
    rchk(8'h04, 8'hF1);
    wr(8'h08, 8'h01, 2'h0);
    rchk(8'h08, 8'h00);
    rst(1'h1, 1'h1, 1'h1, 1'h1);
    // let the pin change pass both synchroniser stages before looking
    flash_write_enable_pin <= 1'h0;
    repeat (4) @(posedge aclk);
    rchk(8'h0C, 8'h42);
    flash_write_enable_pin <= 1'h1;
    wr(8'h08, 8'h01, 2'h0);
    pe(1'h1, 8'h03, 1'h0);
    pe(1'h1, 8'h80, 1'h1);
    pe(1'h0, 8'h00, 1'h1);
    wr(8'h04, 8'h0A, 2'h0);
    rchk(8'h04, 8'hFB);
    fr(17'h00405, 1'h1, 3'h1);
    fr(17'h00005, 1'h0, 3'h0);
    pe(1'h0, 8'h00, 1'h0);
    wr(8'h04, 8'h00, 2'h0);
    pe(1'h0, 8'h00, 1'h1);
    fr(17'h01000, 1'h0, 3'h4);
    fr(17'h08000, 1'h0, 3'h5);
    fr(17'h1FFFF, 1'h0, 3'h7);
    wr(8'h08, 8'h00, 2'h0);
    boot(1'h0);
    chk("branches", 1, nbr);
    chk("branch_addr", 24'hFFF520, cpu_branch_addr);
    rchk(8'h0C, 8'h51);
    chk("ram_writes", 20, wq.size());
    for (int i = 0; i < 20; i++)
        chk("ram_write", i < 4 ? {24'hFFF000 + i[23:0], ~i[7:0]} :
            {24'hFFF51C + i[23:0], eb(i - 4)}, wq[i]);
    chk("erases", 8, eq.size());
    for (int i = 0; i < 8; i++) chk("erase_blk", i, eq[i]);
    boot(1'h1);
    chk("branches", 0, nbr);
    rchk(8'h0C, 8'h75);
    test_done;
end
initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    test_done;
end
endmodule
